// ==== shared/dart_map.svh ====
`ifndef DART_MAP_SVH
`define DART_MAP_SVH
// ==========================================
// Register offsets
`define DART_CFG_OFF 12'h000
`define DART_STAT_OFF 12'h004
// ==========================================
// Configuration fields
`define DART_CFG_CL_LSB 0
`define DART_CFG_AL_LSB 3
`define DART_CFG_BL8_BIT 6
`define DART_CFG_CL_RST 3'h3
`define DART_CFG_AL_RST 3'h0
`define DART_CFG_BL8_RST 1'h0
// ==========================================
// Status fields
`define DART_STAT_OPEN_LSB 0
`define DART_STAT_BUSY_BIT 8
`define DART_STAT_ERR_LSB 9
// ==========================================
// Burst and command figures
`define DART_BL4 4'h4
`define DART_BL8 4'h8
`define DART_CMD_ACT 4'h3
`define DART_CMD_RD 4'h5
`define DART_CMD_WR 4'h4
`define DART_CMD_PRE 4'h2
`define DART_AP_BIT 10
`endif

// ==== shared/dart_pkg.sv ====
package dart_pkg;
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_PRE = 2'h1,
    RD_DATA = 2'h3,
    RD_POST = 2'h2
  } dart_rd_st_t;
  typedef struct packed {
    logic vld;
    logic ap;
    logic [2:0] bank;
    logic [7:0] col;
  } dart_rd_t;
endpackage

// ==== shared/dart_bank_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface dart_bank_if #(parameter int ROW_W = 14);
  logic tick;
  logic act;
  logic pre;
  logic rd_ap;
  logic [4:0] ap_dly;
  logic [ROW_W-1:0] row_in;
  logic open;
  logic [ROW_W-1:0] row;
  modport ctl (output tick, act, pre, rd_ap, ap_dly, row_in, input open, row);
  modport bank (input tick, act, pre, rd_ap, ap_dly, row_in, output open, row);
endinterface
`default_nettype wire

// ==== rtl/dart_bank.sv ====
`timescale 1ns/1ns
`default_nettype none
module dart_bank #(
  parameter int ROW_W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  dart_bank_if.bank b
);
  logic open;
  logic [ROW_W-1:0] row;
  logic ap_pend;
  logic [4:0] ap_cnt;

  assign b.open = open;
  assign b.row = row;

  // ==========================================
  // Row state and auto precharge countdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open <= 1'b0;
      row <= '0;
      ap_pend <= 1'b0;
      ap_cnt <= 5'h0;
    end else begin
      if (b.act) begin
        open <= 1'b1;
        row <= b.row_in;
      end
      if (b.pre) begin
        open <= 1'b0;
        ap_pend <= 1'b0;
      end else if (b.rd_ap) begin
        ap_pend <= 1'b1;
        ap_cnt <= b.ap_dly;
      end else if (ap_pend && b.tick) begin
        if (ap_cnt <= 5'h1) begin
          open <= 1'b0;
          ap_pend <= 1'b0;
        end else begin
          ap_cnt <= ap_cnt - 5'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/dart_top.sv ====
// Notes on behaviour
// - Auto precharge closes row AL plus BL/2 clocks after the read, before the burst ends when CL is above 0
// - First data at AL plus CL
// - Strobe preamble and postamble around data
// - Release data lines after burst ends
`include "dart_map.svh"
`timescale 1ns/1ns
`default_nettype none
module dart_top #(
  parameter int DQ_W = 8,
  parameter int ROW_W = 14,
  parameter int PIPE_D = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [ROW_W-1:0] addr,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_n,
  output logic dqs_o,
  output logic dqs_n_o,
  output logic dqs_oe_n
);
  localparam int PW = 7 + ROW_W;

  // ==========================================
  // Pin synchronisers and clock edges
  logic [PW-1:0] pin_s1, pin_s2;
  logic [2:0] ck_sh;
  logic rise, fall;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= {4'hf, {(PW-4){1'b0}}};
      pin_s2 <= {4'hf, {(PW-4){1'b0}}};
      ck_sh <= 3'h0;
    end else begin
      pin_s1 <= {cs_n, ras_n, cas_n, we_n, ba, addr};
      pin_s2 <= pin_s1;
      ck_sh <= {ck_sh[1:0], ck};
    end
  end
  assign rise = ck_sh[1] & ~ck_sh[2];
  assign fall = ~ck_sh[1] & ck_sh[2];

  logic [3:0] cmd;
  logic [2:0] c_ba;
  logic [ROW_W-1:0] c_addr;
  logic is_act, is_rd, is_wr, is_pre;
  assign cmd = pin_s2[PW-1 -: 4];
  assign c_ba = pin_s2[ROW_W +: 3];
  assign c_addr = pin_s2[ROW_W-1:0];
  assign is_act = rise && cmd == `DART_CMD_ACT;
  assign is_rd = rise && cmd == `DART_CMD_RD;
  assign is_wr = rise && cmd == `DART_CMD_WR;
  assign is_pre = rise && cmd == `DART_CMD_PRE;

  // ==========================================
  // Configuration
  logic [2:0] cfg_cl, cfg_al;
  logic cfg_bl8;
  logic [3:0] rl, bl;
  logic [4:0] ap_dly;
  assign rl = {1'b0, cfg_al} + {1'b0, cfg_cl};
  assign bl = cfg_bl8 ? `DART_BL8 : `DART_BL4;
  assign ap_dly = {2'h0, cfg_al} + {2'h0, bl[3:1]};

  // ==========================================
  // Banks
  logic [7:0] open_v;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bank
      dart_bank_if #(.ROW_W(ROW_W)) bif ();
      assign bif.tick = rise;
      assign bif.act = is_act && c_ba == 3'(gi);
      assign bif.pre = is_pre && (c_addr[`DART_AP_BIT] || c_ba == 3'(gi));
      assign bif.rd_ap = is_rd && c_addr[`DART_AP_BIT] && c_ba == 3'(gi);
      assign bif.ap_dly = ap_dly;
      assign bif.row_in = c_addr;
      assign open_v[gi] = bif.open;
      dart_bank #(.ROW_W(ROW_W)) u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .b(bif)
      );
    end
  endgenerate

  // ==========================================
  // Read latency pipeline, one slot per clock
  dart_pkg::dart_rd_t pipe [PIPE_D];
  dart_pkg::dart_rd_t start_e, pre_e;
  assign start_e = pipe[rl - 4'h1];
  assign pre_e = pipe[rl - 4'h2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PIPE_D; i++) begin
        pipe[i] <= '0;
      end
    end else if (rise) begin
      pipe[0] <= '{vld: is_rd, ap: c_addr[`DART_AP_BIT], bank: c_ba, col: c_addr[7:0]};
      for (int i = 1; i < PIPE_D; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  // ==========================================
  // Burst engine
  function automatic logic [DQ_W-1:0] elem(input logic [2:0] b, input logic [7:0] c,
                                           input logic [3:0] i);
    logic [10:0] s;
    s = {b, c} + {7'h0, i};
    return DQ_W'(s);
  endfunction

  dart_pkg::dart_rd_st_t st;
  logic [3:0] rem, idx;
  logic [7:0] cur_col;
  logic [2:0] cur_bank;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= dart_pkg::RD_IDLE;
      rem <= 4'h0;
      idx <= 4'h0;
      cur_col <= 8'h0;
      cur_bank <= 3'h0;
      dq_o <= '0;
      dq_oe_n <= 1'b1;
      dqs_o <= 1'b0;
      dqs_oe_n <= 1'b1;
    end else if (rise) begin
      if (start_e.vld) begin
        st <= dart_pkg::RD_DATA;
        cur_col <= start_e.col;
        cur_bank <= start_e.bank;
        dq_o <= elem(start_e.bank, start_e.col, 4'h0);
        dq_oe_n <= 1'b0;
        dqs_o <= 1'b1;
        dqs_oe_n <= 1'b0;
        idx <= 4'h1;
        rem <= bl - 4'h1;
      end else if (st == dart_pkg::RD_DATA && rem != 4'h0) begin
        dq_o <= elem(cur_bank, cur_col, idx);
        dqs_o <= 1'b1;
        idx <= idx + 4'h1;
        rem <= rem - 4'h1;
      end else if (st == dart_pkg::RD_DATA) begin
        dq_oe_n <= 1'b1;
        dqs_o <= 1'b0;
        st <= pre_e.vld ? dart_pkg::RD_PRE : dart_pkg::RD_POST;
      end else if (pre_e.vld) begin
        st <= dart_pkg::RD_PRE;
        dqs_o <= 1'b0;
        dqs_oe_n <= 1'b0;
      end
    end else if (fall) begin
      if (st == dart_pkg::RD_DATA && rem != 4'h0) begin
        dq_o <= elem(cur_bank, cur_col, idx);
        dqs_o <= 1'b0;
        idx <= idx + 4'h1;
        rem <= rem - 4'h1;
      end else if (st == dart_pkg::RD_POST) begin
        dqs_oe_n <= 1'b1;
        st <= dart_pkg::RD_IDLE;
      end
    end
  end
  assign dqs_n_o = ~dqs_o;

  // ==========================================
  // Command sequence checks, sticky until cleared
  logic [2:0] err, err_set, err_clr;
  logic wr_en;
  assign wr_en = psel && penable && pwrite;
  always_comb begin
    err_set = 3'h0;
    err_set[0] = (is_rd || is_wr) && !open_v[c_ba];
    err_set[1] = is_act && open_v[c_ba];
    err_set[2] = is_rd && (pipe[0].vld || (cfg_bl8 && (pipe[2].vld || (pipe[1].vld && pipe[1].ap))));
  end
  assign err_clr = (wr_en && paddr == `DART_STAT_OFF) ? pwdata[`DART_STAT_ERR_LSB +: 3] : 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= 3'h0;
    end else begin
      // Set wins over a clear in the same cycle
      err <= (err & ~err_clr) | err_set;
    end
  end

  // ==========================================
  // APB slave, zero wait states
  logic mapped;
  assign mapped = paddr == `DART_CFG_OFF || paddr == `DART_STAT_OFF;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_cl <= `DART_CFG_CL_RST;
      cfg_al <= `DART_CFG_AL_RST;
      cfg_bl8 <= `DART_CFG_BL8_RST;
    end else if (wr_en && paddr == `DART_CFG_OFF) begin
      cfg_cl <= pwdata[`DART_CFG_CL_LSB +: 3];
      cfg_al <= pwdata[`DART_CFG_AL_LSB +: 3];
      cfg_bl8 <= pwdata[`DART_CFG_BL8_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      if (paddr == `DART_CFG_OFF) begin
        prdata <= {25'h0, cfg_bl8, cfg_al, cfg_cl};
      end else if (paddr == `DART_STAT_OFF) begin
        prdata <= {20'h0, err, st != dart_pkg::RD_IDLE, open_v};
      end else begin
        prdata <= 32'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/dart_top_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module dart_top_monitor #(
  parameter int DQ_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pslverr,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic dq_oe_n,
  input wire logic dqs_o,
  input wire logic dqs_n_o,
  input wire logic dqs_oe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========
  // Strobe framing
  property p_pair;
    dqs_n_o == ~dqs_o;
  endproperty
  a_pair: assert property (p_pair) else $error("strobe pair split");
  property p_dq_strobe;
    !dq_oe_n |-> !dqs_oe_n;
  endproperty
  a_dq_strobe: assert property (p_dq_strobe) else $error("data without strobe");
  property p_pre;
    $fell(dqs_oe_n) |-> dq_oe_n && !dqs_o;
  endproperty
  a_pre: assert property (p_pre) else $error("bad preamble");
  property p_low;
    !dqs_oe_n && dq_oe_n |-> !dqs_o;
  endproperty
  a_low: assert property (p_low) else $error("strobe high outside data");
  // ==========
  // Release and element timing
  property p_post;
    $rose(dq_oe_n) |-> !dqs_oe_n ##1 (!dqs_oe_n)[*2];
  endproperty
  a_post: assert property (p_post) else $error("postamble cut short");
  property p_rel;
    $rose(dqs_oe_n) |-> dq_oe_n && $past(dq_oe_n, 3);
  endproperty
  a_rel: assert property (p_rel) else $error("strobe released before data");
  property p_edge;
    !dq_oe_n && $changed(dq_o) |-> $changed(dqs_o);
  endproperty
  a_edge: assert property (p_edge) else $error("element off strobe edge");
  property p_hold;
    $changed(dqs_o) && !dq_oe_n |=> $stable(dqs_o)[*2];
  endproperty
  a_hold: assert property (p_hold) else $error("element too short");
  c_burst: cover property ($fell(dq_oe_n));
  c_rel: cover property ($rose(dqs_oe_n));
  c_err: cover property (pslverr);
endmodule
bind dart_top dart_top_monitor #(.DQ_W(DQ_W)) u_dart_top_monitor (.pclk(pclk),
  .presetn(presetn), .pslverr(pslverr), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
  .dqs_o(dqs_o), .dqs_n_o(dqs_n_o), .dqs_oe_n(dqs_oe_n));
`default_nettype wire

// ==== dv/dart_ctl_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dart_ctl_model (
  output logic ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [13:0] addr
);
  logic [3:0] c = 4'hf;
  int rises = 0;
  assign {cs_n, ras_n, cas_n, we_n} = c;
  // ==========
  // Clock kept off the pclk grid so sampling never races
  initial begin
    ck = 1'b0;
    ba = 3'h0;
    addr = 14'h0;
    #25;
    forever #400 ck = ~ck;
  end
  always @(posedge ck) rises++;
  task automatic issue(input logic [3:0] op, input logic [2:0] b, input logic [13:0] a);
    @(negedge ck);
    c = op;
    ba = b;
    addr = a;
    @(negedge ck);
    c = 4'hf;
    // Deselected bus shows no stale value
    ba = ~b;
    addr = ~a;
  endtask
endmodule
`default_nettype wire

// ==== dv/dart_top_tb.sv ====
`include "dart_map.svh"
`timescale 1ns/1ns
`default_nettype none
module dart_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ck, cs_n, ras_n, cas_n, we_n, dq_oe_n, dqs_o, dqs_n_o, dqs_oe_n;
  logic dqs_q, oe_q;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [7:0] dq_o;
  logic [7:0] got[$];
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int checked = 0;
  int seed = 62778;
  int n_rel = 0;
  int fell_at = 0;
  int rd_at = 0;
  always #50 pclk = ~pclk;
  dart_top u_dart_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dqs_o(dqs_o),
    .dqs_n_o(dqs_n_o), .dqs_oe_n(dqs_oe_n));
  dart_ctl_model u_dart_ctl_model (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr));
  // ==========
  // Capture one element per strobe edge
  always @(posedge pclk) begin
    dqs_q <= dqs_o;
    oe_q <= dq_oe_n;
    if (dq_oe_n === 1'b0 && dqs_o !== dqs_q)
      got.push_back(dq_o);
    if (dq_oe_n === 1'b1 && oe_q === 1'b0)
      n_rel++;
  end
  always @(negedge dq_oe_n) fell_at = u_dart_ctl_model.rises;
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] b, input logic [7:0] c, input logic ap, input int n);
    u_dart_ctl_model.issue(`DART_CMD_RD, b, {3'h0, ap, 2'h0, c});
    rd_at = u_dart_ctl_model.rises;
    for (int i = 0; i < n; i++) exp_q.push_back(c + 8'(i));
  endtask
  task automatic wait_ck(input int n);
    repeat (n) @(negedge ck);
  endtask
  task automatic cmp_data();
    chk(got.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got.size()) chk(got[i], exp_q[i]);
    got.delete();
    exp_q.delete();
    n_rel = 0;
  endtask
  task automatic end_sim();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_mismatch++;
    end_sim();
  end
  // ==========
  // Main sequence
  initial begin
    logic [31:0] v, r;
    logic e;
    int cl, al, bl;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk({dq_oe_n, dqs_oe_n, dqs_o, dqs_n_o}, 4'hd);
    apb(1'b0, `DART_CFG_OFF, 32'h0, r, e);
    chk(r, 32'h3);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h80000000);
    for (int t = 0; t < 4; t++) begin
      v = $random(seed);
      cl = 3 + v[1:0];
      al = v[3:2] % 3;
      bl = v[4] ? 8 : 4;
      apb(1'b1, `DART_CFG_OFF, {25'h0, v[4], 3'(al), 3'(cl)}, r, e);
      u_dart_ctl_model.issue(`DART_CMD_ACT, v[7:5], v[29:16]);
      rd(v[7:5], v[15:8], v[30], bl);
      wait_ck(al + cl + bl / 2 + 3);
      chk(fell_at - rd_at, al + cl);
      cmp_data();
      apb(1'b0, `DART_STAT_OFF, 32'h0, r, e);
      chk(32'(r[v[7:5]]), 32'(!v[30]));
      // Close the row by hand only when the read left it open
      if (!v[30]) begin
        u_dart_ctl_model.issue(`DART_CMD_WR, v[7:5], {6'h0, v[15:8]});
        u_dart_ctl_model.issue(`DART_CMD_PRE, v[7:5], 14'h0);
      end
      apb(1'b0, `DART_STAT_OFF, 32'h0, r, e);
      chk(32'(r[v[7:5]]), 32'h0);
      chk(32'(r[11:8]), 32'h0);
    end
    apb(1'b1, `DART_CFG_OFF, 32'h3, r, e);
    u_dart_ctl_model.issue(`DART_CMD_ACT, 3'h2, 14'h0123);
    rd(3'h2, 8'h10, 1'b0, 4);
    rd(3'h2, 8'h40, 1'b0, 4);
    wait_ck(10);
    chk(n_rel, 1);
    cmp_data();
    apb(1'b1, `DART_CFG_OFF, 32'h43, r, e);
    apb(1'b1, `DART_STAT_OFF, 32'he00, r, e);
    u_dart_ctl_model.issue(`DART_CMD_ACT, 3'h3, 14'h0456);
    rd(3'h3, 8'h20, 1'b0, 4);
    rd(3'h3, 8'h80, 1'b1, 8);
    wait_ck(12);
    chk(n_rel, 1);
    cmp_data();
    apb(1'b0, `DART_STAT_OFF, 32'h0, r, e);
    chk({r[11:9], r[3]}, 4'h0);
    rd(3'h3, 8'h00, 1'b0, 8);
    wait_ck(12);
    apb(1'b0, `DART_STAT_OFF, 32'h0, r, e);
    chk(32'(r[9]), 32'h1);
    cmp_data();
    // Corner case: activate an open bank, then BL8 reads three clocks apart
    u_dart_ctl_model.issue(`DART_CMD_ACT, 3'h2, 14'h0123);
    rd(3'h2, 8'h30, 1'b0, 6);
    wait_ck(1);
    rd(3'h2, 8'h50, 1'b0, 8);
    wait_ck(14);
    chk(n_rel, 1);
    cmp_data();
    u_dart_ctl_model.issue(`DART_CMD_PRE, 3'h0, 14'h0400);
    apb(1'b0, `DART_STAT_OFF, 32'h0, r, e);
    chk(32'(r[10]), 32'h1);
    chk(32'(r[11]), 32'h1);
    chk(32'(r[7:0]), 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
